/* File: core/seeq_pkg.sv */
// Behaviour
// - enable-mask write stores argument 0..255 as eight-bit event enable mask
// - enable-mask query returns the stored mask value
// - event-register query returns current standard event register, 0..255
// - clear-status clears event summary bit and every event register; message-available bit is kept
// - operation-complete command sets bit 0 once pending operations finish
// - operation-complete query answers character 1 once pending operations finish
// - error entries leave in first-in-first-out order
// - each error-queue read removes the returned entry
// - more than ten errors replace newest entry with queue-overflow entry
// - after overflow no further errors enter until queue is cleared
// - reading an empty error queue returns no-error code +000
// - system-clear command and power cycle empty the whole error queue
// - instrument reset command leaves error queue contents unchanged
// - input buffer overrun enqueues -350
// - out-of-range parameter enqueues -221, illegal parameter enqueues -223
// - current limit event enqueues +320, current limit trip enqueues +321
// - pulse trigger detection timeout enqueues +302
// - header numeric suffix out of range enqueues -114
// - over-long program mnemonic enqueues -112
// - lost power-on state enqueues +512
// - event-register query clears the register after returning it
// - operation complete flag is bit 0 of standard event register
// - event summary bit, weight 32, set when any enabled event bit set
package seeq_pkg;

  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_STB    = 8'h04;
  localparam logic [7:0] OFF_RESP   = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0c;
  localparam logic [7:0] OFF_ERRCNT = 8'h10;
  localparam logic [7:0] OFF_ESR    = 8'h14;

  typedef enum logic [3:0] {
    SEEQ_OP_NOP     = 4'h0,
    SEEQ_OP_ESE_SET = 4'h1,
    SEEQ_OP_ESE_QRY = 4'h2,
    SEEQ_OP_ESR_QRY = 4'h3,
    SEEQ_OP_CLS     = 4'h4,
    SEEQ_OP_OPC     = 4'h5,
    SEEQ_OP_OPC_QRY = 4'h6,
    SEEQ_OP_SYS_CLR = 4'h7,
    SEEQ_OP_RST     = 4'h8,
    SEEQ_OP_ERR_QRY = 4'h9
  } seeq_op_t;

  typedef struct packed {
    logic [15:0] arg;
    logic [11:0] pad;
    seeq_op_t    op;
  } seeq_cmd_t;

  // first field is the top bit, so overrun lands on bit 0
  typedef struct packed {
    logic pon_lost;
    logic mnem_long;
    logic suffix_range;
    logic pulse_timeout;
    logic clim_trip;
    logic clim_event;
    logic param_illegal;
    logic param_range;
    logic overrun;
  } seeq_err_ev_t;

  localparam int NSRC = 9;
  localparam int SRC_RANGE   = 1;
  localparam int SRC_ILLEGAL = 2;

  localparam logic [15:0] ERR_NONE = 16'h0000;   // +000
  localparam logic [15:0] ERR_QOVF = 16'hfeb6;   // -330
  localparam logic [15:0] MASK_MAX = 16'h00ff;
  localparam logic [15:0] OPC_CHAR = 16'h0031;   // ascii '1'

  localparam logic [15:0] SRC_CODE [NSRC] = '{
    16'hfea2,   // 350
    16'hff23,   // 221
    16'hff21,   // 223
    16'h0140,   // +320
    16'h0141,   // +321
    16'h012e,   // +302
    16'hff8e,   // 114
    16'hff90,   // 112
    16'h0200    // +512
  };
  localparam logic [2:0] SRC_ESR [NSRC] = '{
    3'h3, 3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h5, 3'h5, 3'h3
  };

  localparam int ESR_OPC = 0;
  localparam int ESR_QYE = 2;
  localparam int ESR_PON = 7;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;

endpackage

/* File: core/seeq_core.sv */
`timescale 1ns/1ps
module seeq_core
  import seeq_pkg::*;
#(
  parameter int QUEUE_DEPTH = 10
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [7:0]   addr_i,
  input  wire logic [31:0]  wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [31:0]  rdata_o,
  input  wire logic         ops_pending_i,
  input  wire seeq_err_ev_t err_ev_i,
  output logic              cls_o,
  output logic              inst_reset_o,
  output logic              esb_o,
  output logic              mav_o
);

  localparam int PW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
  localparam int CW = $clog2(QUEUE_DEPTH + 1);
  localparam logic [PW-1:0] LAST_IDX = PW'(QUEUE_DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(QUEUE_DEPTH);

  seeq_cmd_t        cmd;
  logic             cmd_wr;
  logic             do_ese_set;
  logic             do_ese_qry;
  logic             do_esr_qry;
  logic             do_cls;
  logic             do_opc;
  logic             do_opc_qry;
  logic             do_sys_clr;
  logic             do_rst;
  logic             do_err_qry;
  logic             bad_op;
  logic             arg_ok;

  logic [7:0]       mask;
  logic [7:0]       esr;
  logic [7:0]       esr_set;
  logic [7:0]       stb;
  logic [15:0]      resp;
  logic             resp_valid;
  logic             opc_armed;
  logic             opcq_armed;
  logic             opc_done;
  logic             opcq_done;
  logic             cmd_query;

  logic [NSRC-1:0]  pend;
  logic [NSRC-1:0]  ev_vec;
  logic [NSRC-1:0]  grant;
  logic             push;
  logic [3:0]       sel;
  logic [15:0]      q_mem [QUEUE_DEPTH];
  logic [PW-1:0]    head;
  logic [PW-1:0]    tail;
  logic [CW-1:0]    count;
  logic             lock;
  logic             pop;
  logic             q_empty;
  logic             q_room;
  logic             push_acc;
  logic             push_ovf;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == LAST_IDX) ? '0 : PW'(p + 1'b1);
  endfunction

  // command decode
  assign cmd        = seeq_cmd_t'(wdata_i);
  assign cmd_wr     = wr_i && (addr_i == OFF_CMD);
  assign arg_ok     = (cmd.arg <= MASK_MAX);
  assign do_ese_set = cmd_wr && (cmd.op == SEEQ_OP_ESE_SET);
  assign do_ese_qry = cmd_wr && (cmd.op == SEEQ_OP_ESE_QRY);
  assign do_esr_qry = cmd_wr && (cmd.op == SEEQ_OP_ESR_QRY);
  assign do_cls     = cmd_wr && (cmd.op == SEEQ_OP_CLS);
  assign do_opc     = cmd_wr && (cmd.op == SEEQ_OP_OPC);
  assign do_opc_qry = cmd_wr && (cmd.op == SEEQ_OP_OPC_QRY);
  assign do_sys_clr = cmd_wr && (cmd.op == SEEQ_OP_SYS_CLR);
  assign do_rst     = cmd_wr && (cmd.op == SEEQ_OP_RST);
  assign do_err_qry = cmd_wr && (cmd.op == SEEQ_OP_ERR_QRY);
  assign bad_op     = cmd_wr && (cmd.op > SEEQ_OP_ERR_QRY);
  assign cmd_query  = do_ese_qry || do_esr_qry || do_err_qry;

  // enable mask; an out-of-range argument is refused and reported instead
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask <= 8'h00;
    end else if (do_ese_set && arg_ok) begin
      mask <= cmd.arg[7:0];
    end
  end

  // error sources: sticky until granted, one entry per cycle
  assign ev_vec = NSRC'(err_ev_i);

  always_comb begin
    sel  = 4'h0;
    push = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        sel  = 4'(i);
        push = 1'b1;
      end
    end
  end

  // a clear in the same cycle holds the grant back, so the error enters afterwards
  assign grant = (push && !do_sys_clr) ? (NSRC'(1) << sel) : '0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~grant) | ev_vec;
      if (do_ese_set && !arg_ok) begin
        pend[SRC_RANGE] <= 1'b1;
      end
      if (bad_op) begin
        pend[SRC_ILLEGAL] <= 1'b1;
      end
    end
  end

  // error queue
  assign q_empty  = (count == '0);
  assign pop      = do_err_qry && !q_empty;
  assign q_room   = (count < FULL_CNT) || pop;
  assign push_acc = push && !do_sys_clr && !lock && q_room;
  assign push_ovf = push && !do_sys_clr && !lock && !q_room;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      head  <= '0;
      tail  <= '0;
      count <= '0;
      lock  <= 1'b0;
    end else if (do_sys_clr) begin
      head  <= '0;
      tail  <= '0;
      count <= '0;
      lock  <= 1'b0;
    end else begin
      if (pop) begin
        head <= ptr_inc(head);
      end
      if (push_acc) begin
        tail <= ptr_inc(tail);
      end
      if (push_ovf) begin
        lock <= 1'b1;
      end
      if (push_acc && !pop) begin
        count <= CW'(count + 1'b1);
      end else if (pop && !push_acc) begin
        count <= CW'(count - 1'b1);
      end
    end
  end

  // storage has no reset; only entries between head and tail are ever read
  always_ff @(posedge clk_i) begin
    if (push_acc) begin
      q_mem[tail] <= SRC_CODE[sel];
    end else if (push_ovf) begin
      q_mem[(tail == '0) ? LAST_IDX : PW'(tail - 1'b1)] <= ERR_QOVF;
    end
  end

  // pending-operation waits; reset cancels both, clear-status cancels only the operation-complete command wait
  assign opc_done  = opc_armed && !ops_pending_i;
  assign opcq_done = opcq_armed && !ops_pending_i && !cmd_query;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      opc_armed  <= 1'b0;
      opcq_armed <= 1'b0;
    end else begin
      if (do_opc) begin
        opc_armed <= 1'b1;
      end else if (do_cls || do_rst || opc_done) begin
        opc_armed <= 1'b0;
      end
      if (do_opc_qry) begin
        opcq_armed <= 1'b1;
      end else if (do_rst || opcq_done) begin
        opcq_armed <= 1'b0;
      end
    end
  end

  // standard event register: any set in the cycle of a clear survives it
  always_comb begin
    esr_set = 8'h00;
    if (push && !do_sys_clr) begin
      esr_set[SRC_ESR[sel]] = 1'b1;
    end
    if (opc_done) begin
      esr_set[ESR_OPC] = 1'b1;
    end
    if ((do_err_qry && q_empty) || (cmd_query && resp_valid)) begin
      esr_set[ESR_QYE] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      esr <= ESR_RESET;
    end else if (do_cls || do_esr_qry) begin
      esr <= esr_set;
    end else begin
      esr <= esr | esr_set;
    end
  end

  // one-deep output queue
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp       <= 16'h0000;
      resp_valid <= 1'b0;
    end else begin
      if (do_ese_qry) begin
        resp <= {8'h00, mask};
      end else if (do_esr_qry) begin
        resp <= {8'h00, esr};
      end else if (do_err_qry) begin
        resp <= q_empty ? ERR_NONE : q_mem[head];
      end else if (opcq_done) begin
        resp <= OPC_CHAR;
      end
      if (cmd_query || opcq_done) begin
        resp_valid <= 1'b1;
      end else if (rd_i && (addr_i == OFF_RESP)) begin
        resp_valid <= 1'b0;
      end
    end
  end

  // status byte; other summary bits belong to groups outside this block
  always_comb begin
    stb          = 8'h00;
    stb[STB_ESB] = |(esr & mask);
    stb[STB_MAV] = resp_valid;
  end

  assign esb_o = stb[STB_ESB];
  assign mav_o = stb[STB_MAV];

  // clear-status pulse lets the other event groups clear themselves
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cls_o        <= 1'b0;
      inst_reset_o <= 1'b0;
    end else begin
      cls_o        <= do_cls;
      inst_reset_o <= do_rst;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        OFF_STB:    rdata_o <= {24'h000000, stb};
        OFF_RESP:   rdata_o <= {resp_valid, 15'h0000, resp};
        OFF_MASK:   rdata_o <= {24'h000000, mask};
        OFF_ERRCNT: rdata_o <= {lock, 23'h000000, 8'(count)};
        OFF_ESR:    rdata_o <= {24'h000000, esr};
        default:    rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_quiet;
    !cmd_wr && (pend == '0);
  endsequence

  sequence s_lone_overrun;
    (((ev_vec == NSRC'(1)) && q_empty && !lock) and s_quiet) ##1 (!cmd_wr && (ev_vec == '0));
  endsequence

  sequence s_opc_wait;
    opc_armed && ops_pending_i && !do_cls && !do_rst;
  endsequence

  a_mask_write: assert property (do_ese_set && arg_ok |=> mask == $past(cmd.arg[7:0]))
    else $error("mask not stored");
  a_mask_query: assert property (do_ese_qry |=> resp_valid && resp == {8'h00, $past(mask)})
    else $error("mask query answer wrong");
  a_esr_query: assert property (do_esr_qry |=> resp == {8'h00, $past(esr)} && resp_valid)
    else $error("event query answer wrong");
  a_esr_clear: assert property (do_esr_qry && esr_set == 8'h00 |=> esr == 8'h00)
    else $error("event register not cleared by query");
  a_cls_effect: assert property (do_cls && esr_set == 8'h00 |=> esr == 8'h00 && cls_o)
    else $error("clear-status incomplete");
  a_opc_bit: assert property (opc_armed && !ops_pending_i |=> esr[ESR_OPC])
    else $error("operation complete bit not set");
  a_opc_hold: assert property (opc_armed && ops_pending_i && !do_cls && !do_rst
                               |=> opc_armed)
    else $error("operation complete wait dropped");
  a_opcq_char: assert property (opcq_done |=> resp == OPC_CHAR && resp_valid)
    else $error("operation complete query answer wrong");
  a_fifo_head: assert property (pop |=> resp == $past(q_mem[head]))
    else $error("error queue not oldest first");
  a_pop_count: assert property (pop && !push_acc |=> count == $past(count) - 1'b1)
    else $error("read did not remove entry");
  a_overflow_set: assert property (push_ovf |=> lock && count == FULL_CNT)
    else $error("overflow not recorded");
  a_lock_block: assert property (lock && !do_sys_clr |=> lock && count <= $past(count))
    else $error("entry accepted after overflow");
  a_empty_read: assert property (do_err_qry && q_empty |=> resp == ERR_NONE)
    else $error("empty queue read not no-error");
  a_sys_clear: assert property (do_sys_clr |=> q_empty && !lock)
    else $error("system clear left entries");
  a_rst_keep: assert property (do_rst && !push |=> count == $past(count))
    else $error("instrument reset changed queue");
  a_overrun_code: assert property (s_lone_overrun |=> count == 1 && q_mem[head] == SRC_CODE[0])
    else $error("overrun code not enqueued");
  a_esb_read: assert property (rd_i && addr_i == OFF_STB
      |=> rdata_o[STB_ESB] == ($past(esr & mask) != 8'h00))
    else $error("event summary bit missing");
  a_range_refuse: assert property (do_ese_set && !arg_ok
      |=> pend[SRC_RANGE] && mask == $past(mask))
    else $error("out-of-range mask not refused");
  a_illegal_op: assert property (bad_op
      |=> pend[SRC_ILLEGAL])
    else $error("illegal opcode not reported");
  a_push_code: assert property (push_acc
      |=> q_mem[$past(tail)] == $past(SRC_CODE[sel]))
    else $error("wrong error code stored");
  a_ovf_entry: assert property (push_ovf
      |=> q_mem[PW'(($past(tail) + QUEUE_DEPTH - 1) % QUEUE_DEPTH)] == ERR_QOVF)
    else $error("newest entry not replaced by overflow");
  a_query_error: assert property (do_err_qry && q_empty
      |=> esr[ESR_QYE])
    else $error("empty queue read not flagged");
  a_mask_read: assert property (rd_i && addr_i == OFF_MASK
      |=> rdata_o[7:0] == $past(mask))
    else $error("mask read wrong");
  a_rst_queue: assert property (do_rst && !push
      |=> inst_reset_o && head == $past(head) && tail == $past(tail))
    else $error("instrument reset moved queue pointers");
  a_cls_cancel: assert property (do_cls
      |=> !opc_armed)
    else $error("clear-status left operation wait armed");
  a_opcq_wait: assert property (opcq_armed && ops_pending_i && !do_rst
      |=> opcq_armed)
    else $error("operation complete query answered early");
  a_esr_source: assert property (push && !do_sys_clr
      |=> esr[$past(SRC_ESR[sel])])
    else $error("error class bit not set");
  a_cls_pulse: assert property (cls_o
      |-> $past(do_cls))
    else $error("stray clear-status pulse");
  a_lock_cause: assert property ($rose(lock)
      |-> $past(push_ovf))
    else $error("lock set without overflow");
  a_push_count: assert property (push_acc && !pop
      |=> count == $past(count) + 1'b1)
    else $error("entry not added");
  a_mav_clear: assert property (rd_i && addr_i == OFF_RESP && !cmd_query && !opcq_done
      |=> !mav_o)
    else $error("answer not released by read");
  a_opc_after_wait: assert property (s_opc_wait ##1 !ops_pending_i
      |=> esr[ESR_OPC])
    else $error("operation complete bit missing after wait");

endmodule

/* File: dv/seeq_inst_model.sv */
`timescale 1ns/1ps
module seeq_inst_model
  import seeq_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       fire_i,
  input  wire logic [3:0] src_i,
  input  wire logic       busy_i,
  output seeq_err_ev_t    err_ev_o,
  output logic            ops_pending_o
);
  // one event per fire cycle; a held fire would count as several events
  always @(posedge clk_i) begin
    err_ev_o <= seeq_err_ev_t'(fire_i ? 9'h001 << src_i : 9'h000);
    ops_pending_o <= busy_i;
  end
endmodule

/* File: dv/status_event_error_queue_tb.sv */
`timescale 1ns/1ps
module status_event_error_queue_tb;
  import seeq_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic [7:0]   addr_i = 8'h00;
  logic [31:0]  wdata_i = 32'h0;
  logic         wr_i = 1'b0;
  logic         rd_i = 1'b0;
  logic [31:0]  rdata_o;
  logic         ops_pending_i;
  seeq_err_ev_t err_ev_i;
  logic         cls_o;
  logic         inst_reset_o;
  logic         esb_o;
  logic         mav_o;
  logic         fire = 1'b0;
  logic [3:0]   src = 4'h0;
  logic         busy = 1'b0;
  int           err_count = 0;
  int           compares = 0;
  int           cycles = 0;
  int           esr = 'h80;
  int           mask = 0;
  bit           lock = 0;
  logic [15:0]  q[$];
  logic [31:0]  lfsr = 32'h8a88;
  logic [31:0]  got;
  const int     code[9] = '{-350, -221, -223, 320, 321, 302, -114, -112, 512};
  const int     ebit[9] = '{3, 4, 4, 3, 3, 3, 5, 5, 3};

  always #25 clk_i = ~clk_i;

  seeq_core #(.QUEUE_DEPTH(10)) i_seeq_core (
    .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ops_pending_i,
    .err_ev_i, .cls_o, .inst_reset_o, .esb_o, .mav_o
  );
  seeq_inst_model i_seeq_inst_model (
    .clk_i, .fire_i(fire), .src_i(src), .busy_i(busy), .err_ev_o(err_ev_i),
    .ops_pending_o(ops_pending_i)
  );

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
    chk(got, e);
  endtask

  task automatic cmd(input seeq_op_t op, input logic [15:0] arg);
    wr(OFF_CMD, {arg, 12'h000, op});
  endtask

  task automatic query(input seeq_op_t op, input logic [15:0] arg, input logic [15:0] e);
    cmd(op, arg);
    rchk(OFF_RESP, {16'h8000, e});
  endtask

  task automatic push(input int i);
    esr |= 1 << ebit[i];
    if (!lock && q.size() < 10) begin
      q.push_back(16'(code[i]));
    end else if (!lock) begin
      q[9] = 16'(-330);
      lock = 1;
    end
  endtask

  task automatic ev(input int i);
    push(i);
    @(posedge clk_i);
    fire <= 1'b1;
    src <= 4'(i);
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic cnt();
    rchk(OFF_ERRCNT, {lock, 23'h0, 8'(q.size())});
  endtask

  task automatic conclude();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ceiling is about twenty times the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("Error at %0t: timeout", $time);
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(OFF_ESR, 32'h80);
    rchk(OFF_STB, 32'h0);
    query(SEEQ_OP_ESR_QRY, 16'h0, 16'h0080);
    esr = 0;
    rchk(OFF_ESR, 32'h0);
    $display("test 1 done");
    for (int k = 0; k < 4; k++) begin
      mask = int'(rnd() & 32'hff);
      cmd(SEEQ_OP_ESE_SET, 16'(mask));
      query(SEEQ_OP_ESE_QRY, 16'h0, 16'(mask));
    end
    cmd(SEEQ_OP_ESE_SET, 16'd300);
    push(1);
    // opcode above the last one defined
    wr(OFF_CMD, 32'h0000_000c);
    push(2);
    rchk(OFF_MASK, 32'(mask));
    cnt();
    query(SEEQ_OP_ERR_QRY, 16'h0, q.pop_front());
    query(SEEQ_OP_ERR_QRY, 16'h0, q.pop_front());
    $display("test 2 done");
    cmd(SEEQ_OP_ESE_SET, 16'd1);
    @(posedge clk_i) busy <= 1'b1;
    cmd(SEEQ_OP_OPC, 16'h0);
    repeat (5) @(posedge clk_i);
    rchk(OFF_ESR, 32'(esr));
    rchk(OFF_STB, 32'h0);
    @(posedge clk_i) busy <= 1'b0;
    repeat (4) @(posedge clk_i);
    esr |= 1;
    rchk(OFF_ESR, 32'(esr));
    rchk(OFF_STB, 32'h20);
    @(posedge clk_i) busy <= 1'b1;
    cmd(SEEQ_OP_OPC_QRY, 16'h0);
    repeat (4) @(posedge clk_i);
    rchk(OFF_STB, 32'h20);
    @(posedge clk_i) busy <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk(OFF_STB, 32'h30);
    chk({30'h0, esb_o, mav_o}, 32'h3);
    rchk(OFF_RESP, 32'h8000_0031);
    $display("test 3 done");
    cmd(SEEQ_OP_CLS, 16'h0);
    chk({31'h0, cls_o}, 32'h1);
    esr = 0;
    rchk(OFF_ESR, 32'h0);
    rchk(OFF_STB, 32'h0);
    chk({30'h0, esb_o, mav_o}, 32'h0);
    $display("test 4 done");
    cmd(SEEQ_OP_SYS_CLR, 16'h0);
    q.delete();
    cnt();
    // every source once, then random ones past the queue depth
    for (int k = 0; k < 12; k++) begin
      ev(k < 9 ? k : int'(rnd() % 9));
    end
    cnt();
    cmd(SEEQ_OP_RST, 16'h0);
    chk({31'h0, inst_reset_o}, 32'h1);
    cnt();
    while (q.size() > 0) begin
      query(SEEQ_OP_ERR_QRY, 16'h0, q.pop_front());
    end
    query(SEEQ_OP_ERR_QRY, 16'h0, 16'h0000);
    esr |= 4;
    ev(0);
    cnt();
    cmd(SEEQ_OP_SYS_CLR, 16'h0);
    lock = 0;
    ev(3);
    cnt();
    query(SEEQ_OP_ESR_QRY, 16'h0, 16'(esr));
    rchk(OFF_ESR, 32'h0);
    $display("test 5 done");
    // power cycle with entries still queued
    ev(5);
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    q.delete();
    lock = 0;
    mask = 0;
    cnt();
    rchk(OFF_ESR, 32'h80);
    rchk(OFF_MASK, 32'(mask));
    $display("test 6 done");
    conclude();
  end
endmodule
